/* File: design/smlc_pkg.sv */
// Purpose: shared constants and types for the mode and load control block
// Assumes: 50 MHz core clock, straps decoded off chip into two-bit levels
// Notes: four-level strap codes 0, R, F, 1 map to 2'h0..2'h3
`default_nettype none
package smlc_pkg;
  // four-level strap encoding
  localparam logic [1:0] STRAP_GND   = 2'h0;
  localparam logic [1:0] STRAP_RES   = 2'h1;
  localparam logic [1:0] STRAP_FLOAT = 2'h2;
  localparam logic [1:0] STRAP_HIGH  = 2'h3;

  localparam int NUM_EVENTS = 8;
  localparam int EE_BYTES   = 16;
  localparam logic [7:0] EE_DEV_ADDR = 8'ha0;
  localparam logic [3:0] STRAP_WAIT  = 4'h8;
  localparam logic [7:0] SCL_HALF    = 8'h7d; // 126-cycle half period
  localparam int EE_TIMEOUT_US = 20000;
  localparam int CLK_MHZ       = 50;
  localparam int EE_TIMEOUT_CYC = EE_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    SMLC_TEST   = 3'b000,
    SMLC_MASTER = 3'b001,
    SMLC_SLAVE  = 3'b010,
    SMLC_RSVD   = 3'b011,
    SMLC_NONE   = 3'b100
  } smlc_mode_t;

  typedef enum logic [2:0] {
    LD_IDLE  = 3'b000,
    LD_START = 3'b001,
    LD_BUSY  = 3'b010,
    LD_DONE  = 3'b011,
    LD_FAIL  = 3'b100
  } smlc_ld_t;

  typedef struct packed {
    logic o;
    logic oe_n;
  } smlc_od_t;

  typedef struct packed {
    logic [NUM_EVENTS-1:0] enable;
    logic [NUM_EVENTS-1:0] clear;
  } smlc_irq_ctl_t;
endpackage
`default_nettype wire

/* File: design/smlc_sync.sv */
// Purpose: two-flop synchroniser for a bus of pin inputs
// Assumes: inputs come from outside the clk domain
// Notes: first stage is read only by the second stage
`default_nettype none
module smlc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] q_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_r <= '1;
      q_r  <= '1;
    end else begin
      s1_r <= d;
      q_r  <= s1_r;
    end
  end
  assign q = q_r;
endmodule // smlc_sync
`default_nettype wire

/* File: design/smlc_top.sv */
// Purpose: mode strap decode, eeprom load control, interrupt pin driver
// Assumes: straps arrive pre-decoded as two-bit levels; eeprom byte
//          transfer engine lives elsewhere and reports via ee_* ports
// Notes: serial clock pin sampled by clk; outputs registered, scl_o and int_o tied low
`default_nettype none
module smlc_top
  import smlc_pkg::*;
#(
  parameter int TIMEOUT_CYC = EE_TIMEOUT_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [1:0]            interface_mode_strap,
  input  wire logic [1:0]            address_strap_low,
  input  wire logic [1:0]            address_strap_high,
  input  wire logic                  load_req_n,
  input  wire logic                  serial_mgmt_clock_pin,
  input  wire logic                  ee_byte_done,
  input  wire logic                  ee_nack,
  input  wire logic [NUM_EVENTS-1:0] events,
  input  wire smlc_irq_ctl_t         irq_ctl,
  output logic                       load_done_n,
  output logic                       ee_start,
  output logic                       scl_o,
  output logic                       scl_oe_n,
  output logic                       int_o,
  output logic                       int_oe_n,
  output logic                       slave_reset,
  output logic                       test_port_en,
  output logic [3:0]                 dev_addr,
  output logic                       mode_valid,
  output logic                       scl_rise
);
  logic [1:0] req_scl_s;
  logic       req_s;
  logic       scl_s;
  smlc_sync #(.W(2)) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({load_req_n, serial_mgmt_clock_pin}),
    .q     (req_scl_s)
  );
  assign req_s = req_scl_s[1];
  assign scl_s = req_scl_s[0];

  // strap capture: straps settle a few cycles after reset release
  smlc_mode_t mode_r,  mode_nxt;
  logic [3:0] wait_r,  wait_nxt;
  logic [3:0] addr_r,  addr_nxt;
  logic       valid_r, valid_nxt;
  always_comb begin
    mode_nxt  = mode_r;
    wait_nxt  = wait_r;
    addr_nxt  = addr_r;
    valid_nxt = valid_r;
    if (!valid_r) begin
      if (wait_r != STRAP_WAIT) begin
        wait_nxt = wait_r + 4'h1;
      end else begin
        valid_nxt = 1'b1;
        addr_nxt  = {address_strap_high, address_strap_low};
        case (interface_mode_strap)
          STRAP_GND:   mode_nxt = SMLC_TEST;
          STRAP_FLOAT: mode_nxt = SMLC_MASTER;
          STRAP_HIGH:  mode_nxt = SMLC_SLAVE;
          default:     mode_nxt = SMLC_RSVD;
        endcase
      end
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_r  <= SMLC_NONE;
      wait_r  <= 4'h0;
      addr_r  <= 4'h0;
      valid_r <= 1'b0;
    end else begin
      mode_r  <= mode_nxt;
      wait_r  <= wait_nxt;
      addr_r  <= addr_nxt;
      valid_r <= valid_nxt;
    end
  end

  // eeprom load sequencer
  smlc_ld_t    ld_r,    ld_nxt;
  logic [4:0]  cnt_r,   cnt_nxt;
  logic [31:0] tmo_r,   tmo_nxt;
  logic        start_r, start_nxt;
  logic        is_master;
  assign is_master = (mode_r == SMLC_MASTER);
  always_comb begin
    ld_nxt    = ld_r;
    cnt_nxt   = cnt_r;
    tmo_nxt   = tmo_r;
    start_nxt = 1'b0;
    case (ld_r)
      LD_IDLE: begin
        if (is_master && !req_s) begin
          ld_nxt = LD_START;
        end
      end
      LD_START: begin
        start_nxt = 1'b1;
        cnt_nxt   = 5'h0;
        tmo_nxt   = 32'h0;
        ld_nxt    = LD_BUSY;
      end
      LD_BUSY: begin
        tmo_nxt = tmo_r + 32'h1;
        if (ee_nack || tmo_r == 32'(TIMEOUT_CYC)) begin
          ld_nxt = LD_FAIL;
        end else if (ee_byte_done) begin
          cnt_nxt = cnt_r + 5'h1;
          if (cnt_r == 5'(EE_BYTES - 1)) begin
            ld_nxt = LD_DONE;
          end
        end
      end
      LD_DONE: ld_nxt = LD_DONE; // held low request is harmless
      LD_FAIL: begin
        // a fresh request edge retries; a stuck low request cannot
        if (req_s) begin
          ld_nxt = LD_IDLE;
        end
      end
      default: ld_nxt = LD_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      ld_r    <= LD_IDLE;
      cnt_r   <= 5'h0;
      tmo_r   <= 32'h0;
      start_r <= 1'b0;
    end else begin
      ld_r    <= ld_nxt;
      cnt_r   <= cnt_nxt;
      tmo_r   <= tmo_nxt;
      start_r <= start_nxt;
    end
  end

  // serial clock generation while master, plus edge detect on the pin
  logic [7:0] half_r, half_nxt;
  logic       sclo_r, sclo_nxt;
  logic       scl_d_r;
  logic       rise_r, rise_nxt;
  logic       mst_act;
  assign mst_act = is_master && (ld_r == LD_BUSY);
  always_comb begin
    half_nxt = half_r;
    sclo_nxt = 1'b1;
    rise_nxt = scl_s && !scl_d_r;
    if (mst_act) begin
      sclo_nxt = sclo_r;
      if (half_r == SCL_HALF) begin
        half_nxt = 8'h0;
        sclo_nxt = !sclo_r;
      end else begin
        half_nxt = half_r + 8'h1;
      end
    end else begin
      half_nxt = 8'h0;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      half_r  <= 8'h0;
      sclo_r  <= 1'b1;
      scl_d_r <= 1'b1;
      rise_r  <= 1'b0;
    end else begin
      half_r  <= half_nxt;
      sclo_r  <= sclo_nxt;
      scl_d_r <= scl_s;
      rise_r  <= rise_nxt;
    end
  end

  // interrupt: sticky pending, set wins over clear
  logic [NUM_EVENTS-1:0] pend_r, pend_nxt;
  logic                  int_r,  int_nxt;
  always_comb begin
    pend_nxt = (pend_r & ~irq_ctl.clear) | events;
    int_nxt  = |(pend_nxt & irq_ctl.enable);
  end

  // output registers
  logic done_n_r, done_n_nxt;
  logic srst_r,   srst_nxt;
  logic tpe_r,    tpe_nxt;
  always_comb begin
    case (mode_r)
      SMLC_MASTER: done_n_nxt = (ld_nxt != LD_DONE);
      SMLC_SLAVE:  done_n_nxt = req_s;
      default:     done_n_nxt = 1'b1;
    endcase
    srst_nxt = (mode_r == SMLC_SLAVE) && !req_s;
    tpe_nxt  = (mode_r == SMLC_TEST);
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_r   <= '0;
      int_r    <= 1'b0;
      done_n_r <= 1'b1;
      srst_r   <= 1'b0;
      tpe_r    <= 1'b0;
    end else begin
      pend_r   <= pend_nxt;
      int_r    <= int_nxt;
      done_n_r <= done_n_nxt;
      srst_r   <= srst_nxt;
      tpe_r    <= tpe_nxt;
    end
  end

  assign load_done_n  = done_n_r;
  assign ee_start     = start_r;
  assign scl_o        = 1'b0; // open drain, only ever pulls low
  assign scl_oe_n     = sclo_r;
  assign int_o        = 1'b0;
  assign int_oe_n     = !int_r;
  assign slave_reset  = srst_r;
  assign test_port_en = tpe_r;
  assign dev_addr     = addr_r;
  assign mode_valid   = valid_r;
  assign scl_rise     = rise_r;

  sequence s_load_req;
    is_master && ld_r == LD_IDLE && !req_s;
  endsequence
  sequence s_load_start;
    ##2 ee_start;
  endsequence

  a_load_start_seq: assert property (@(posedge clk) disable iff (reset)
    s_load_req |-> s_load_start) else $error("load did not start");
  a_done_after_load: assert property (@(posedge clk) disable iff (reset)
    (is_master && ld_r == LD_DONE) |-> ##1 !load_done_n)
    else $error("done not low after load");
  a_done_high_fail: assert property (@(posedge clk) disable iff (reset)
    (is_master && ld_r == LD_FAIL) |-> ##1 load_done_n)
    else $error("done low after failed load");
  a_done_kept_low: assert property (@(posedge clk) disable iff (reset)
    (is_master && ld_r == LD_DONE && !req_s) |-> ##1 ld_r == LD_DONE)
    else $error("load state left done");
  a_slave_follow: assert property (@(posedge clk) disable iff (reset)
    (mode_r == SMLC_SLAVE) |-> ##1 load_done_n == $past(req_s))
    else $error("slave done not following request");
  a_slave_hold_rst: assert property (@(posedge clk) disable iff (reset)
    (mode_r == SMLC_SLAVE && !req_s) |=> slave_reset)
    else $error("slave reset not held");
  a_scl_master_only: assert property (@(posedge clk) disable iff (reset)
    !scl_oe_n |-> $past(mst_act, 1) || $past(mst_act, 2))
    else $error("serial clock driven while not master");
  a_int_enabled: assert property (@(posedge clk) disable iff (reset)
    (|(events & irq_ctl.enable)) |=> !int_oe_n)
    else $error("interrupt not raised");
  a_int_release: assert property (@(posedge clk) disable iff (reset)
    !(|(((pend_r & ~irq_ctl.clear) | events) & irq_ctl.enable))
      |=> int_oe_n) else $error("interrupt not released");
  a_mode_stable: assert property (@(posedge clk) disable iff (reset)
    valid_r |=> $stable(mode_r) && $stable(dev_addr))
    else $error("mode changed after capture");
  a_test_port: assert property (@(posedge clk) disable iff (reset)
    (mode_r == SMLC_TEST) |=> test_port_en)
    else $error("test port not enabled");
endmodule // smlc_top
`default_nettype wire

/* File: bench/smlc_ee_model.sv */
// Purpose: byte engine stand-in for the eeprom load
// Assumes: one load per ee_start pulse
// Notes: gap sets byte spacing, slow gaps exceed the load timeout
`default_nettype none
module smlc_ee_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ee_start,
  input  wire logic [7:0] gap,
  input  wire logic [4:0] nack_at,
  output logic            ee_byte_done,
  output logic            ee_nack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_r;
  logic [4:0] byte_r;
  logic       run_r;
  always_ff @(posedge clk) begin
    ee_byte_done <= 1'b0;
    ee_nack <= 1'b0;
    if (reset) begin
      run_r <= 1'b0;
    end else if (ee_start) begin
      run_r <= 1'b1;
      cnt_r <= 8'h00;
      byte_r <= 5'h00;
    end else if (run_r && cnt_r == gap) begin
      cnt_r <= 8'h00;
      byte_r <= byte_r + 5'h01;
      // failure only where a scenario asks for it
      if (byte_r + 5'h01 == nack_at) begin
        ee_nack <= 1'b1;
        run_r <= 1'b0;
      end else begin
        ee_byte_done <= 1'b1;
        run_r <= (byte_r != 5'h0f);
      end
    end else if (run_r) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule // smlc_ee_model
`default_nettype wire

/* File: bench/test_smbus_mode_eeprom_load_control.sv */
// Purpose: self-checking bench for mode decode, load and interrupt
// Assumes: load timeout shortened to 200 cycles
// Notes: mode is fixed per reset, so each mode test resets
`default_nettype none
module test_smbus_mode_eeprom_load_control;
  import smlc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, req_n = 1, host_scl = 1, scl_run = 0;
  logic [1:0] mode_s = STRAP_FLOAT;
  logic [1:0] a_lo = 2'h1, a_hi = 2'h2;
  logic [7:0] events = 8'h00, gap = 8'h0a;
  logic [4:0] nack_at = 5'h00;
  smlc_irq_ctl_t irq_ctl = '0;
  logic ld_n, st, scl_o, scl_oe_n, int_o, int_oe_n, s_rst, tp, mv, rise;
  logic bd, nk, scl_wire;
  logic [3:0] addr;
  int failures = 0, checked = 0, cyc = 0, starts = 0, rises = 0;
  // released clock wire returns to its pull-up or the host level
  assign scl_wire = scl_oe_n ? (host_scl | !scl_run) : 1'b0;
  always #10 clk = ~clk;
  always #80 if (scl_run) host_scl = ~host_scl;
  smlc_top #(.TIMEOUT_CYC(200)) u_dut (.clk(clk), .reset(reset),
    .interface_mode_strap(mode_s), .address_strap_low(a_lo),
    .address_strap_high(a_hi), .load_req_n(req_n),
    .serial_mgmt_clock_pin(scl_wire), .ee_byte_done(bd), .ee_nack(nk),
    .events(events), .irq_ctl(irq_ctl), .load_done_n(ld_n),
    .ee_start(st), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .int_o(int_o),
    .int_oe_n(int_oe_n), .slave_reset(s_rst), .test_port_en(tp),
    .dev_addr(addr), .mode_valid(mv), .scl_rise(rise));
  smlc_ee_model u_ee (.clk(clk), .reset(reset), .ee_start(st),
    .gap(gap), .nack_at(nack_at), .ee_byte_done(bd), .ee_nack(nk));
  always @(posedge clk) begin
    cyc++;
    if (st === 1'b1) starts++;
    if (rise === 1'b1) rises++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic do_reset(input logic [1:0] s);
    reset = 1;
    req_n = 1;
    mode_s = s;
    tick(2);
    reset = 0;
    for (int i = 0; i < 20 && mv !== 1'b1; i++) tick(1);
    // mode outputs register one edge after capture
    tick(1);
    chk_bit(mv, 1'b1);
  endtask
  task automatic t_master_ok;
    logic sc;
    sc = 0;
    do_reset(STRAP_FLOAT);
    chk_bit(addr === 4'h9, 1'b1);
    chk_bit(ld_n, 1'b1);
    chk_bit(tp, 1'b0);
    gap = 8'h0a;
    nack_at = 5'h00;
    req_n = 0;
    for (int i = 0; i < 300 && ld_n !== 1'b0; i++) begin
      tick(1);
      sc |= (scl_oe_n === 1'b0);
    end
    chk_bit(starts == 1, 1'b1);
    chk_bit(sc, 1'b1);
    chk_bit(ld_n, 1'b0);
    tick(40);
    chk_bit(ld_n, 1'b0);
    chk_bit(starts == 1, 1'b1);
    $display("test master load done");
  endtask
  task automatic t_master_fail;
    for (int k = 0; k < 2; k++) begin
      do_reset(STRAP_FLOAT);
      // bad byte, then a byte spacing that stretches the whole load past the load timeout
      nack_at = k ? 5'h00 : 5'h05;
      gap = k ? 8'h14 : 8'h02;
      req_n = 0;
      tick(400);
      chk_bit(ld_n, 1'b1);
      chk_bit(scl_oe_n, 1'b1);
    end
    // a fresh request edge after a failure retries the load
    req_n = 1;
    tick(4);
    gap = 8'h0a;
    starts = 0;
    req_n = 0;
    for (int i = 0; i < 300 && ld_n !== 1'b0; i++) tick(1);
    chk_bit(starts == 1 && ld_n === 1'b0, 1'b1);
    $display("test master fail done");
  endtask
  task automatic t_slave;
    starts = 0;
    a_lo = 2'h3;
    a_hi = 2'h0;
    do_reset(STRAP_HIGH);
    chk_bit(addr === 4'h3, 1'b1);
    rises = 0;
    scl_run = 1;
    tick(4);
    chk_bit(ld_n, 1'b1);
    chk_bit(s_rst, 1'b0);
    req_n = 0;
    tick(4);
    chk_bit(ld_n, 1'b0);
    chk_bit(s_rst, 1'b1);
    req_n = 1;
    tick(30);
    scl_run = 0;
    chk_bit(ld_n, 1'b1);
    chk_bit(s_rst, 1'b0);
    chk_bit(starts == 0 && rises > 2, 1'b1);
    chk_bit(scl_oe_n, 1'b1);
    $display("test slave done");
  endtask
  task automatic t_test_mode;
    starts = 0;
    // reserved strap level: no mode output may act
    do_reset(STRAP_RES);
    req_n = 0;
    tick(10);
    chk_bit(tp, 1'b0);
    chk_bit(ld_n, 1'b1);
    chk_bit(starts == 0 && s_rst === 1'b0, 1'b1);
    do_reset(STRAP_GND);
    chk_bit(tp, 1'b1);
    // a late strap change must not move the mode
    mode_s = STRAP_FLOAT;
    req_n = 0;
    tick(20);
    chk_bit(tp, 1'b1);
    chk_bit(starts == 0, 1'b1);
    $display("test port mode done");
  endtask
  task automatic t_irq;
    irq_ctl.enable = 8'h04;
    events = 8'h01;
    tick(1);
    events = 8'h00;
    tick(2);
    chk_bit(int_oe_n, 1'b1);
    events = 8'h04;
    tick(1);
    events = 8'h00;
    tick(1);
    chk_bit(int_oe_n, 1'b0);
    chk_bit(int_o, 1'b0);
    irq_ctl.clear = 8'h04;
    tick(1);
    irq_ctl.clear = 8'h00;
    tick(1);
    chk_bit(int_oe_n, 1'b1);
    // two enabled sources: clearing one keeps the pin low
    irq_ctl.enable = 8'h06;
    events = 8'h06;
    tick(1);
    events = 8'h00;
    irq_ctl.clear = 8'h04;
    tick(1);
    chk_bit(int_oe_n, 1'b0);
    // event and clear in one cycle: the event wins
    irq_ctl.clear = 8'h02;
    events = 8'h02;
    tick(1);
    chk_bit(int_oe_n, 1'b0);
    events = 8'h00;
    tick(1);
    irq_ctl.clear = 8'h00;
    tick(1);
    chk_bit(int_oe_n, 1'b1);
    $display("test interrupt done");
  endtask
  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    tick(2);
    t_master_ok();
    t_master_fail();
    t_slave();
    t_test_mode();
    t_irq();
    finish_test();
  end
endmodule // test_smbus_mode_eeprom_load_control
`default_nettype wire
